/* hw/tcc_edge_sync.sv */
/*
 * tcc_edge_sync: two-flop synchroniser with rise/fall detection.
 * assumes an asynchronous pin level and one timer clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tcc_edge_sync import tcc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin and edges
    input wire logic pin,
    output tcc_edge_t edge_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign edge_o = '{rise: sync_q & ~prev_q, fall: ~sync_q & prev_q};
endmodule // tcc_edge_sync
`default_nettype wire

/* hw/tcc_timer.sv */
/*
 * tcc_timer: one channel of the 16-bit timer with capture and compare.
 * assumes an avalon-mm master, pins from outside the clock domain and
 * a prescaler tick from logic on the same clock.
 */
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

// How it works
// (R1) capture mode 00 disables hardware capture; it is the reset value.
// (R2) mode 01: pin a rise loads capture a, pin b rise loads capture b.
// (R3) mode 10: pin a rise loads capture a, its fall loads capture b.
// (R4) only in mode 10 the pin a interrupt fires on its falling edge.
// (R5) mode 11: byte timer flip-flop rise loads a, fall loads b.
// (R6) writing 0 to the soft capture bit copies counter into capture a.
// (R7) software keeps the prescaler running while using soft capture.
// (R8) two comparators check counter against both compares, each interrupts.
// (R9) counter clears on compare b match only when clear is enabled.
// (R10) main flip-flop toggles on enabled matches and capture loads.
// (R11) main command 00 toggles, 10 sets; clear code taken as 01.
// (R12) main flip-flop drives the timer output pin.
// (R13) second flip-flop toggles on compare b match and capture b load, own pin.
// (R14) second command 00 toggles, 10 sets; clear taken as 01.
// (R15) interval mode: compare b gives periodic match, counter clears.
// (R16) event mode counts each rising edge of the pin.
// (R17) software reads event count via soft capture then capture a.
// (R18) software keeps the prescaler running in event counter mode.
// (R19) in pulse mode software keeps compare a below compare b.
// (R20) with double buffer, buffer moves to compare a on compare b match.
// (R21) double buffer on: writes go to buffer; off: both written.
// (R22) run bit counts or stops and holds the counter cleared.
// (R23) pins are synchronised and edge detected before use.
module tcc_timer import tcc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // prescaled internal count tick
    input wire logic presc_tick,
    // pins
    input wire logic capture_pin_a,
    input wire logic capture_pin_b,
    input wire logic byte_timer_ff,
    // outputs
    output logic toggle_out_a,
    output logic toggle_out_b,
    output logic match_a_irq,
    output logic match_b_irq,
    output logic pin_a_irq,
    output logic pin_b_irq
);
    tcc_edge_t pa_e;
    tcc_edge_t pb_e;
    tcc_edge_t bf_e;
    logic [31:0] mode_q;
    logic [31:0] tgl_q;
    logic [31:0] ctrl_q;
    logic [15:0] up_counter_q;
    logic [15:0] buf_q;
    logic [15:0] compare_a;
    logic [15:0] compare_b;
    logic [15:0] capture_a;
    logic [15:0] capture_b;
    logic ack_q;
    logic [31:0] rdata_d;
    logic wr_go;
    logic soft_cap;
    logic match_a;
    logic match_b;
    logic load_a;
    logic load_b;
    logic cmp_a_load;
    logic [15:0] cmp_a_din;
    logic count_en;
    logic [1:0] main_cmd;
    logic [1:0] sec_cmd;
    logic sticky_match_a_q;
    logic sticky_match_b_q;
    tcc_cap_mode_t cap_mode;

    // byte-enable merge, used for every writable register
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // byte-enable merge of a 16-bit register held in the low half
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] be);
        logic [31:0] r;
        r = merge({16'h0000, old}, nw, be);
        return r[15:0];
    endfunction

    // flip-flop next value from a command
    function automatic logic ff_next(input logic cur, input logic [1:0] cmd,
                                     input logic tgl);
        logic r;
        r = cur ^ tgl;
        if (cmd == FF_CMD_TOGGLE) r = ~cur;
        else if (cmd == FF_CMD_SET) r = 1'b1;
        else if (cmd == FF_CMD_CLEAR) r = 1'b0;
        return r;
    endfunction

    tcc_edge_sync u_sync_a (.clk(clk), .rst(rst), .pin(capture_pin_a),
        .edge_o(pa_e)); // R23
    tcc_edge_sync u_sync_b (.clk(clk), .rst(rst), .pin(capture_pin_b),
        .edge_o(pb_e)); // R23
    tcc_edge_sync u_sync_f (.clk(clk), .rst(rst), .pin(byte_timer_ff),
        .edge_o(bf_e)); // R23

    // each access takes one wait cycle, then completes
    assign wr_go = avs_write & ack_q;
    assign cap_mode = tcc_cap_mode_t'(mode_q[MODE_CAP_LSB +: 2]);

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
        end
    end

    // control registers; soft capture bit reads back as 1
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= MODE_RESET; // R1
            tgl_q <= TOGGLE_RESET;
            ctrl_q <= CTRL_RESET;
        end else if (wr_go) begin
            if (avs_address == OFF_MODE) begin
                mode_q <= merge(mode_q, avs_writedata, avs_byteenable)
                    | (32'h1 << MODE_SOFTCAP_BIT);
            end else if (avs_address == OFF_TOGGLE) begin
                tgl_q <= merge(tgl_q, avs_writedata, avs_byteenable)
                    | TOGGLE_RESET;
            end else if (avs_address == OFF_CTRL) begin
                ctrl_q <= merge(ctrl_q, avs_writedata, avs_byteenable);
            end
        end
    end

    assign soft_cap = wr_go && avs_address == OFF_MODE && avs_byteenable[0]
        && !avs_writedata[MODE_SOFTCAP_BIT]; // R6
    assign main_cmd = (wr_go && avs_address == OFF_TOGGLE
        && avs_byteenable[0]) ? avs_writedata[TGL_MAIN_CMD_LSB +: 2]
        : FF_CMD_NONE;
    assign sec_cmd = (wr_go && avs_address == OFF_TOGGLE
        && avs_byteenable[0]) ? avs_writedata[TGL_SEC_CMD_LSB +: 2]
        : FF_CMD_NONE;

    // comparators
    assign match_a = up_counter_q == compare_a; // R8
    assign match_b = up_counter_q == compare_b; // R8 R15

    // capture strobes
    always_comb begin
        load_a = soft_cap; // R6
        load_b = 1'b0;
        case (cap_mode)
            TCC_CAP_OFF: begin
                load_b = 1'b0; // R1
            end
            TCC_CAP_TWO_PINS: begin
                load_a = soft_cap | pa_e.rise; // R2
                load_b = pb_e.rise; // R2
            end
            TCC_CAP_PIN_EDGES: begin
                load_a = soft_cap | pa_e.rise; // R3
                load_b = pa_e.fall; // R3
            end
            TCC_CAP_BYTE_FF: begin
                load_a = soft_cap | bf_e.rise; // R5
                load_b = bf_e.fall; // R5
            end
            default: load_b = 1'b0;
        endcase
    end

    tcc_word_reg u_cap_a (.clk(clk), .rst(rst), .load(load_a),
        .din(up_counter_q), .dout(capture_a));
    tcc_word_reg u_cap_b (.clk(clk), .rst(rst), .load(load_b),
        .din(up_counter_q), .dout(capture_b));
    tcc_word_reg u_cmp_b (.clk(clk), .rst(rst),
        .load(wr_go && avs_address == OFF_CMP_B),
        .din(merge16(compare_b, avs_writedata, avs_byteenable)),
        .dout(compare_b));

    // compare a: direct write when unbuffered, transfer on b match
    always_comb begin
        cmp_a_load = 1'b0;
        cmp_a_din = buf_q;
        if (wr_go && avs_address == OFF_CMP_A && !ctrl_q[CTRL_DB_BIT]) begin
            cmp_a_load = 1'b1; // R21
            cmp_a_din = merge16(buf_q, avs_writedata, avs_byteenable);
        end else if (ctrl_q[CTRL_DB_BIT] && match_b) begin
            cmp_a_load = 1'b1; // R20
        end
    end

    tcc_word_reg u_cmp_a (.clk(clk), .rst(rst), .load(cmp_a_load),
        .din(cmp_a_din), .dout(compare_a));

    always_ff @(posedge clk) begin
        if (rst) begin
            buf_q <= WORD16_RESET;
        end else if (wr_go && avs_address == OFF_CMP_A) begin
            buf_q <= merge16(buf_q, avs_writedata, avs_byteenable); // R21
        end
    end

    // count source: pin rise in event mode, else prescaler tick
    assign count_en = (mode_q[MODE_CLK_LSB +: 2] == CLK_SEL_PIN)
        ? pa_e.rise : presc_tick; // R16

    always_ff @(posedge clk) begin
        if (rst) begin
            up_counter_q <= WORD16_RESET;
        end else if (!ctrl_q[CTRL_RUN_BIT]) begin
            up_counter_q <= WORD16_RESET; // R22
        end else if (match_b && mode_q[MODE_CLE_BIT]) begin
            up_counter_q <= WORD16_RESET; // R9 R15
        end else if (count_en) begin
            up_counter_q <= up_counter_q + 16'h0001; // R9
        end
    end

    // match pulses once per new equality
    always_ff @(posedge clk) begin
        if (rst) begin
            sticky_match_a_q <= 1'b0;
            sticky_match_b_q <= 1'b0;
            match_a_irq <= 1'b0;
            match_b_irq <= 1'b0;
        end else begin
            sticky_match_a_q <= match_a;
            sticky_match_b_q <= match_b;
            match_a_irq <= match_a & ~sticky_match_a_q; // R8
            match_b_irq <= match_b & ~sticky_match_b_q; // R8 R15
        end
    end

    // pin interrupts
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_a_irq <= 1'b0;
            pin_b_irq <= 1'b0;
        end else begin
            pin_a_irq <= (cap_mode == TCC_CAP_PIN_EDGES)
                ? pa_e.fall : pa_e.rise; // R4
            pin_b_irq <= pb_e.rise;
        end
    end

    // timer flip-flops driving the output pins
    always_ff @(posedge clk) begin
        if (rst) begin
            toggle_out_a <= 1'b0;
            toggle_out_b <= 1'b0;
        end else begin
            toggle_out_a <= ff_next(toggle_out_a, main_cmd, // R11 R12
                (tgl_q[TGL_EN_LSB] & match_a & ~sticky_match_a_q)
                | (tgl_q[TGL_EN_LSB + 1] & match_b & ~sticky_match_b_q)
                | (tgl_q[TGL_EN_LSB + 2] & load_a)
                | (tgl_q[TGL_EN_LSB + 3] & load_b)); // R10
            toggle_out_b <= ff_next(toggle_out_b, sec_cmd, // R14
                (match_b & ~sticky_match_b_q) | load_b); // R13
        end
    end

    // read mux
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (avs_address == OFF_MODE) rdata_d = mode_q;
        else if (avs_address == OFF_TOGGLE) rdata_d = tgl_q;
        else if (avs_address == OFF_CTRL) rdata_d = ctrl_q;
        else if (avs_address == OFF_CMP_A) rdata_d = {16'h0000, compare_a};
        else if (avs_address == OFF_CMP_B) rdata_d = {16'h0000, compare_b};
        else if (avs_address == OFF_CAP_A) rdata_d = {16'h0000, capture_a};
        else if (avs_address == OFF_CAP_B) rdata_d = {16'h0000, capture_b};
        else if (avs_address == OFF_STATUS)
            rdata_d = {30'h0, toggle_out_b, toggle_out_a};
        else if (avs_address == OFF_COUNT)
            rdata_d = {16'h0000, up_counter_q};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~ack_q) begin
            avs_readdata <= rdata_d;
        end
    end

    // assertions
    a_cap_off_idle: assert property (@(posedge clk) disable iff (rst) // R1
        (cap_mode == TCC_CAP_OFF && !soft_cap) |=> $stable(capture_b))
        else $error("capture b changed while capture disabled");
    a_soft_cap_load: assert property (@(posedge clk) disable iff (rst) // R6
        soft_cap |=> capture_a == $past(up_counter_q))
        else $error("soft capture did not load capture a");
    a_pin_b_cap: assert property (@(posedge clk) disable iff (rst) // R2
        (cap_mode == TCC_CAP_TWO_PINS && pb_e.rise)
        |=> capture_b == $past(up_counter_q))
        else $error("pin b rise did not load capture b");
    a_width_cap: assert property (@(posedge clk) disable iff (rst) // R3
        (cap_mode == TCC_CAP_PIN_EDGES && pa_e.fall)
        |=> capture_b == $past(up_counter_q))
        else $error("pin a fall did not load capture b");
    a_pin_irq_edge: assert property (@(posedge clk) disable iff (rst) // R4
        (cap_mode == TCC_CAP_PIN_EDGES && pa_e.rise) |=> !pin_a_irq)
        else $error("pin a interrupt on rise in width mode");
    a_pin_irq_fall: assert property (@(posedge clk) disable iff (rst) // R4
        (cap_mode == TCC_CAP_PIN_EDGES && pa_e.fall) |=> pin_a_irq)
        else $error("pin a interrupt missing on fall in width mode");
    a_clear_on_b: assert property (@(posedge clk) disable iff (rst) // R9
        (match_b && mode_q[MODE_CLE_BIT] && ctrl_q[CTRL_RUN_BIT])
        |=> up_counter_q == 16'h0000)
        else $error("counter not cleared on compare b match");
    a_stop_clear: assert property (@(posedge clk) disable iff (rst) // R22
        !ctrl_q[CTRL_RUN_BIT] |=> up_counter_q == 16'h0000)
        else $error("stopped counter not held cleared");
    a_db_transfer: assert property (@(posedge clk) disable iff (rst) // R20
        (ctrl_q[CTRL_DB_BIT] && match_b && !wr_go)
        |=> compare_a == $past(buf_q))
        else $error("buffer not moved into compare a");
    a_main_set: assert property (@(posedge clk) disable iff (rst) // R11
        main_cmd == FF_CMD_SET |=> toggle_out_a)
        else $error("main flip-flop not set by command");
endmodule // tcc_timer
`default_nettype wire

/* hw/tcc_word_reg.sv */
/*
 * tcc_word_reg: a 16-bit register loaded by a strobe, registered output.
 * assumes synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module tcc_word_reg import tcc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // load
    input wire logic load,
    input wire logic [15:0] din,
    output logic [15:0] dout
);
    always_ff @(posedge clk) begin
        if (rst) begin
            dout <= WORD16_RESET;
        end else if (load) begin
            dout <= din;
        end
    end
endmodule // tcc_word_reg
`default_nettype wire

/* pkg/tcc_pkg.sv */
/*
 * tcc_pkg: constants and carriers of the sixteen-bit capture/compare timer.
 * assumes a 32-bit avalon-mm slave with word addressing in bytes.
 */
package tcc_pkg;
    // register byte offsets
    localparam logic [5:0] OFF_MODE = 6'h00;
    localparam logic [5:0] OFF_TOGGLE = 6'h04;
    localparam logic [5:0] OFF_CTRL = 6'h08;
    localparam logic [5:0] OFF_CMP_A = 6'h0C;
    localparam logic [5:0] OFF_CMP_B = 6'h10;
    localparam logic [5:0] OFF_CAP_A = 6'h14;
    localparam logic [5:0] OFF_CAP_B = 6'h18;
    localparam logic [5:0] OFF_STATUS = 6'h1C;
    localparam logic [5:0] OFF_COUNT = 6'h20;
    // mode register fields
    localparam int MODE_CLK_LSB = 0;
    localparam int MODE_CAP_LSB = 2;
    localparam int MODE_CLE_BIT = 4;
    localparam int MODE_SOFTCAP_BIT = 5;
    // toggle register fields
    localparam int TGL_EN_LSB = 0;
    localparam int TGL_MAIN_CMD_LSB = 4;
    localparam int TGL_SEC_CMD_LSB = 6;
    // control register fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_DB_BIT = 1;
    localparam int CTRL_PRESC_BIT = 2;
    // reset values
    localparam logic [31:0] MODE_RESET = 32'h0000_0020;
    localparam logic [31:0] TOGGLE_RESET = 32'h0000_00F0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] WORD16_RESET = 16'h0000;
    // flip-flop command codes
    localparam logic [1:0] FF_CMD_TOGGLE = 2'h0;
    localparam logic [1:0] FF_CMD_SET = 2'h2;
    localparam logic [1:0] FF_CMD_CLEAR = 2'h1;
    localparam logic [1:0] FF_CMD_NONE = 2'h3;
    // capture modes
    typedef enum logic [1:0] {
        TCC_CAP_OFF = 2'b00,
        TCC_CAP_TWO_PINS = 2'b01,
        TCC_CAP_PIN_EDGES = 2'b10,
        TCC_CAP_BYTE_FF = 2'b11
    } tcc_cap_mode_t;
    // count clock selects
    localparam logic [1:0] CLK_SEL_PIN = 2'h0;
    // synchronised pin edges carried together
    typedef struct packed {
        logic rise;
        logic fall;
    } tcc_edge_t;
endpackage

/* tb/tb.sv */
/*
 * tb: self-checking bench of tcc_timer over avalon-mm.
 * assumes tcc_pkg and tcc_pins_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tcc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic presc_tick = 1'b0;
    logic pin_a, pin_b, byte_ff;
    logic toggle_out_a, toggle_out_b, match_a_irq, match_b_irq;
    logic pin_a_irq, pin_b_irq;
    logic ta_p = 1'b0;
    logic tb_p = 1'b0;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_ma = 0, n_mb = 0, n_pa = 0, n_pb = 0, n_ta = 0, n_tb = 0;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    string nam_q[$];

    always #20 clk = ~clk;

    tcc_timer tcc_timer_i (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .presc_tick(presc_tick), .capture_pin_a(pin_a),
        .capture_pin_b(pin_b), .byte_timer_ff(byte_ff),
        .toggle_out_a(toggle_out_a), .toggle_out_b(toggle_out_b),
        .match_a_irq(match_a_irq), .match_b_irq(match_b_irq),
        .pin_a_irq(pin_a_irq), .pin_b_irq(pin_b_irq));
    tcc_pins_model tcc_pins_model_i (.clk(clk), .pin_a(pin_a),
        .pin_b(pin_b), .byte_ff(byte_ff));

    task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // event counters on the design's outputs
    always @(posedge clk) begin
        n_ma <= n_ma + int'(match_a_irq === 1'b1);
        n_mb <= n_mb + int'(match_b_irq === 1'b1);
        n_pa <= n_pa + int'(pin_a_irq === 1'b1);
        n_pb <= n_pb + int'(pin_b_irq === 1'b1);
        n_ta <= n_ta + int'(toggle_out_a !== ta_p);
        n_tb <= n_tb + int'(toggle_out_b !== tb_p);
        ta_p <= toggle_out_a;
        tb_p <= toggle_out_b;
    end

    // read results are compared against the oldest note
    always @(posedge clk) begin
        if (avs_read && !avs_waitrequest && exp_q.size() > 0) begin
            if (msk_q[0] != 32'h0)
                check(nam_q[0], avs_readdata & msk_q[0], exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
            void'(nam_q.pop_front());
        end
    end

    task automatic bus(input logic [5:0] a, input logic wr,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e,
                      input logic [31:0] m, input string nm,
                      output logic [31:0] q);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        nam_q.push_back(nm);
        bus(a, 1'b0, 32'h0, q);
    endtask

    task automatic tick(input int n);
        @(posedge clk);
        presc_tick <= 1'b1;
        repeat (n) @(posedge clk);
        presc_tick <= 1'b0;
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [31:0] mw(logic [1:0] cs, logic [1:0] cm,
                                       logic cle, logic sc);
        return {26'h0, sc, cle, cm, cs};
    endfunction

    initial begin
        #2000000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        logic [15:0] rnd, ca, cb, c, p, n;
        logic [31:0] q;
        logic [1:0] mc[8];
        logic [1:0] sc[8];
        logic [1:0] st[8];
        int pa0, pb0, ma0, mb0, ta0, tb0;
        mc = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h3, 2'h0, 2'h1, 2'h3};
        sc = '{2'h1, 2'h3, 2'h2, 2'h3, 2'h0, 2'h0, 2'h3, 2'h1};
        st = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0, 2'h3, 2'h2, 2'h0};
        rnd = 16'hCF0E;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(OFF_MODE, MODE_RESET, 32'hFFFF_FFFF, "mode_rst", q);
        rd(OFF_TOGGLE, TOGGLE_RESET, 32'hFF, "toggle_rst", q);
        rd(OFF_CTRL, CTRL_RESET, 32'h7, "ctrl_rst", q);
        rd(OFF_CAP_A, 32'h0, 32'hFFFF, "cap_a_rst", q);
        wr(6'h3C, 32'hA5A5_A5A5);
        rd(6'h3C, 32'h0, 32'hFFFF_FFFF, "unmapped", q);
        // event counting on pin a, read through soft capture
        rnd = lfsr(rnd);
        n = 16'(1 + rnd % 7);
        wr(OFF_CTRL, 32'h5);
        wr(OFF_MODE, mw(CLK_SEL_PIN, 2'h0, 1'b0, 1'b1));
        pa0 = n_pa;
        repeat (int'(n)) begin
            tcc_pins_model_i.drive(0, 1'b1);
            tcc_pins_model_i.drive(0, 1'b0);
        end
        check("pin_a_irq_cnt", 32'(n_pa - pa0), 32'(n));
        wr(OFF_MODE, mw(CLK_SEL_PIN, 2'h0, 1'b0, 1'b0));
        rd(OFF_CAP_A, 32'(n), 32'hFFFF, "event_cnt", q);
        // every capture mode against one edge sequence
        ca = n;
        cb = 16'h0;
        for (int m = 0; m < 4; m++) begin
            wr(OFF_MODE, mw(2'h1, 2'(m), 1'b0, 1'b1));
            rd(OFF_MODE, mw(2'h1, 2'(m), 1'b0, 1'b1), 32'h3F, "mode", q);
            bus(OFF_COUNT, 1'b0, 32'h0, q);
            c = q[15:0];
            pa0 = n_pa;
            pb0 = n_pb;
            tcc_pins_model_i.drive(0, 1'b1);
            check("pin_a_irq_rise", 32'(n_pa - pa0), (m == 2) ? 0 : 1);
            tick(2);
            tcc_pins_model_i.drive(1, 1'b1);
            check("pin_b_irq_rise", 32'(n_pb - pb0), 32'h1);
            tick(2);
            tcc_pins_model_i.drive(0, 1'b0);
            check("pin_a_irq_fall", 32'(n_pa - pa0), 32'h1);
            tick(2);
            tcc_pins_model_i.drive(2, 1'b1);
            tick(2);
            tcc_pins_model_i.drive(2, 1'b0);
            tcc_pins_model_i.drive(1, 1'b0);
            check("pin_b_irq_fall", 32'(n_pb - pb0), 32'h1);
            if (m == 1) begin
                ca = c;
                cb = c + 16'h2;
            end else if (m == 2) begin
                ca = c;
                cb = c + 16'h4;
            end else if (m == 3) begin
                ca = c + 16'h6;
                cb = c + 16'h8;
            end
            rd(OFF_CAP_A, 32'(ca), 32'hFFFF, "cap_a", q);
            rd(OFF_CAP_B, 32'(cb), 32'hFFFF, "cap_b", q);
        end
        // interval timer with toggles on both matches
        rnd = lfsr(rnd);
        p = 16'(3 + rnd % 5);
        wr(OFF_CMP_B, 32'(p));
        wr(OFF_CMP_A, 32'h1);
        rd(OFF_CMP_A, 32'h1, 32'hFFFF, "cmp_a", q);
        wr(OFF_TOGGLE, 32'hF3);
        rd(OFF_TOGGLE, 32'hF3, 32'hFF, "toggle", q);
        wr(OFF_MODE, mw(2'h1, 2'h0, 1'b1, 1'b1));
        wr(OFF_CTRL, 32'h4);
        rd(OFF_COUNT, 32'h0, 32'hFFFF, "count_stop", q);
        wr(OFF_CTRL, 32'h5);
        {ma0, mb0, ta0, tb0} = {n_ma, n_mb, n_ta, n_tb};
        tick(12 * int'(p + 1));
        repeat (4) @(posedge clk);
        check("match_b_n", 32'(n_mb - mb0 inside {[11:13]}), 32'h1);
        check("match_a_n", 32'(n_ma - ma0 inside {[11:13]}), 32'h1);
        check("tog_a_n", 32'(n_ta - ta0), 32'(n_ma - ma0 + n_mb - mb0));
        check("tog_b_n", 32'(n_tb - tb0), 32'(n_mb - mb0));
        bus(OFF_COUNT, 1'b0, 32'h0, q);
        check("count_max", 32'(q[15:0] <= p), 32'h1);
        wr(OFF_MODE, mw(2'h1, 2'h0, 1'b0, 1'b1));
        wr(OFF_CTRL, 32'h4);
        wr(OFF_CTRL, 32'h5);
        tick(2 * int'(p + 1));
        rd(OFF_COUNT, 32'(2 * (p + 1)), 32'hFFFF, "free_run", q);
        // double buffer: write lands in the buffer, moves on compare b match
        wr(OFF_CTRL, 32'h6);
        wr(OFF_CMP_A, 32'h2);
        rd(OFF_CMP_A, 32'h1, 32'hFFFF, "cmp_a_db", q);
        wr(OFF_CTRL, 32'h7);
        tick(int'(p) + 1);
        rd(OFF_CMP_A, 32'h2, 32'hFFFF, "cmp_a_xfer", q);
        // flip-flop commands, both fields
        for (int i = 0; i < 8; i++) begin
            wr(OFF_TOGGLE, {24'h0, sc[i], mc[i], 4'h0});
            rd(OFF_STATUS, 32'(st[i]), 32'h3, "ff_status", q);
        end
        end_of_test();
    end
endmodule // tb
`default_nettype wire

/* tb/tcc_pins_model.sv */
/*
 * tcc_pins_model: far side of the timer, capture pins and byte timer ff.
 * assumes the bench calls drive() from its main sequence only.
 */
`timescale 1ns/1ps
`default_nettype none
module tcc_pins_model (
    // clock
    input wire logic clk,
    // levels towards the timer
    output logic pin_a,
    output logic pin_b,
    output logic byte_ff
);
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
        byte_ff = 1'b0;
    end
    // change one line, then hold it long enough for sync and capture
    task automatic drive(input int which, input logic v);
        @(posedge clk);
        case (which)
            0: pin_a <= v;
            1: pin_b <= v;
            default: byte_ff <= v;
        endcase
        repeat (6) @(posedge clk);
    endtask
endmodule // tcc_pins_model
`default_nettype wire
